// [design/sac_dev.sv]
// Purpose: acquisition and conversion sequencer of the converter
// Assumes: link pins synchronous to CLK; conversion clock sampled as a level
// Notes: analog switches are driven as select codes; SAR itself not modelled
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
module sac_dev #(
  parameter int TICK_CYC = sac_pkg::INT_TICK_CYC
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  sac_link_if.dev LINK,
  output logic TRACK,
  output logic HOLD_CAP_NEG,
  output logic [3:0] MUX_POS_SEL,
  output logic [3:0] MUX_NEG_SEL,
  output logic POLARITY_SELECT,
  output logic [1:0] POWER_SELECT,
  output logic CLK_MODE_INT,
  output logic BUSY
);
  import sac_pkg::*;

  //--------------------------------------------------------------
  // elaboration checks
  //--------------------------------------------------------------
  // the internal divider is eight bits wide
  if (TICK_CYC < 1 || TICK_CYC > 255) begin : g_chk
    $error("TICK_CYC must be 1..255");
  end
  // both phase lengths share the four-bit edge counter
  if (ACQ_EDGES < 1 || ACQ_EDGES > 16) begin : g_chk_acq
    $error("ACQ_EDGES must be 1..16");
  end
  if (CONV_CYCLES < 1 || CONV_CYCLES > 16) begin : g_chk_conv
    $error("CONV_CYCLES must be 1..16");
  end
  // the common return code must not alias a channel number
  if (SEL_COMMON < 4'h8) begin : g_chk_common
    $error("SEL_COMMON must lie above the channel codes");
  end
  if (ADDR_MSB != 2) begin : g_chk_addr
    $error("ADDR_MSB must be 2 for eight channels");
  end

  //--------------------------------------------------------------
  // state
  //--------------------------------------------------------------
  typedef struct packed {
    sac_phase_t phase;
    logic [7:0] ctrl;
    logic clk_int;
    logic wr_q;
    logic rd_q;
    logic clk_q;
    logic [3:0] edge_cnt;
    logic [7:0] div_cnt;
    logic track;
    logic cap_neg;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    logic done_b;
    logic busy;
  } sac_dev_state_t;

  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
  localparam logic [3:0] ACQ_LAST = 4'(ACQ_EDGES - 1);
  localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);

  // strobe detectors start at the idle pin level so reset makes no false edge
  localparam sac_dev_state_t DEV_RESET = '{
    phase: SAC_IDLE,
    ctrl: CTRL_RESET,
    clk_int: 1'b0,
    wr_q: 1'b1,
    rd_q: 1'b1,
    clk_q: 1'b0,
    edge_cnt: 4'h0,
    div_cnt: 8'h00,
    track: 1'b1,
    cap_neg: 1'b0,
    pos_sel: 4'h0,
    neg_sel: SEL_COMMON,
    done_b: 1'b1,
    busy: 1'b0
  };

  sac_dev_state_t s;
  sac_dev_state_t next_s;
  logic wr_rise;
  logic rd_fall;
  logic tick;
  logic [7:0] byte_in;
  logic [2:0] addr;
  logic [2:0] pair_addr;

  //--------------------------------------------------------------
  // link events
  //--------------------------------------------------------------
  assign wr_rise = !s.wr_q && LINK.wr_b && !LINK.cs_b;
  assign rd_fall = s.rd_q && !LINK.rd_b && !LINK.cs_b;
  // internal clock makes its own falling edges; otherwise the pin's
  assign tick = s.clk_int ? (s.div_cnt == TICK_LAST) : (s.clk_q && !LINK.conv_clk);
  assign byte_in = LINK.data;
  assign addr = byte_in[ADDR_MSB:0];
  // pairs are even/odd neighbours; either member may be the positive side
  assign pair_addr = {addr[2:1], ~addr[0]};

  //--------------------------------------------------------------
  // next state
  //--------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.wr_q = LINK.wr_b;
    next_s.rd_q = LINK.rd_b;
    next_s.clk_q = LINK.conv_clk;
    if (s.clk_int && !tick) begin
      next_s.div_cnt = s.div_cnt + 8'h01;
    end else begin
      next_s.div_cnt = 8'h00;
    end
    if (rd_fall) begin
      next_s.done_b = 1'b1;
    end
    if (wr_rise) begin
      next_s.done_b = 1'b1;
      next_s.edge_cnt = 4'h0;
      // power-down codes keep the last clock mode
      if (byte_in[PWR_HI_BIT:PWR_LO_BIT] == PWR_INT_CLK) begin
        next_s.clk_int = 1'b1;
      end else if (byte_in[PWR_HI_BIT:PWR_LO_BIT] == PWR_EXT_CLK) begin
        next_s.clk_int = 1'b0;
      end
      if (s.phase == SAC_ACQ_EXT) begin
        // second write ends the open acquisition
        next_s.ctrl[PWR_HI_BIT:PWR_LO_BIT] = byte_in[PWR_HI_BIT:PWR_LO_BIT];
        next_s.track = 1'b0;
        next_s.cap_neg = 1'b1;
        next_s.phase = SAC_CONV;
      end else begin
        // also reached mid-conversion: the old result is dropped
        next_s.ctrl = byte_in;
        next_s.track = 1'b1;
        next_s.cap_neg = 1'b0;
        if (byte_in[CFG_SEL_BIT]) begin
          next_s.pos_sel = {1'b0, addr};
          next_s.neg_sel = SEL_COMMON;
        end else begin
          next_s.pos_sel = {1'b0, addr};
          next_s.neg_sel = {1'b0, pair_addr};
        end
        if (byte_in[ACQ_MODE_BIT]) begin
          next_s.phase = SAC_ACQ_EXT;
        end else begin
          next_s.phase = SAC_ACQ_INT;
        end
      end
    end else if (tick) begin
      case (s.phase)
        SAC_ACQ_INT: begin
          next_s.edge_cnt = s.edge_cnt + 4'h1;
          if (s.edge_cnt == ACQ_LAST) begin
            next_s.track = 1'b0;
            next_s.cap_neg = 1'b1;
            next_s.edge_cnt = 4'h0;
            next_s.phase = SAC_CONV;
          end
        end
        SAC_CONV: begin
          next_s.edge_cnt = s.edge_cnt + 4'h1;
          if (s.edge_cnt == CONV_LAST) begin
            next_s.cap_neg = 1'b0;
            next_s.edge_cnt = 4'h0;
            next_s.done_b = 1'b0;
            next_s.phase = SAC_IDLE;
          end
        end
        default: begin
          next_s.edge_cnt = s.edge_cnt;
        end
      endcase
    end
    next_s.busy = (next_s.phase != SAC_IDLE);
  end

  //--------------------------------------------------------------
  // state register
  //--------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= DEV_RESET;
    end else if (CE) begin
      // CE low holds the edge detectors too, so no strobe edge is doubled
      s <= next_s;
    end
  end

  //--------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------
  assign LINK.done_b = s.done_b;
  assign TRACK = s.track;
  assign HOLD_CAP_NEG = s.cap_neg;
  assign MUX_POS_SEL = s.pos_sel;
  assign MUX_NEG_SEL = s.neg_sel;
  assign POLARITY_SELECT = s.ctrl[POL_SEL_BIT];
  assign POWER_SELECT = s.ctrl[PWR_HI_BIT:PWR_LO_BIT];
  assign CLK_MODE_INT = s.clk_int;
  assign BUSY = s.busy;
endmodule : sac_dev

// [design/sac_host.sv]
// Purpose: bus-driven controller that writes control bytes to the converter
// Assumes: AHB-Lite single word transfers, one slave, always OKAY
// Notes: a strobe request while a strobe runs is dropped and flagged
`timescale 1ns/1ns
module sac_host #(
  parameter int HALF_CYC = sac_pkg::EXT_HALF_CYC
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  sac_link_if.host LINK
);
  import sac_pkg::*;

  if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_chk
    $error("HALF_CYC must be 1..255");
  end

  typedef struct packed {
    sac_hphase_t phase;
    logic is_read;
    logic [1:0] cnt;
    logic [7:0] ctrl;
    logic dropped;
    logic clk_run;
    logic [7:0] div_cnt;
    logic cs_b;
    logic wr_b;
    logic rd_b;
    logic conv_clk;
    logic dph_wr;
    logic [3:0] dph_addr;
    logic [31:0] rdata;
  } sac_host_state_t;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
  localparam logic [1:0] STROBE_LAST = 2'(STROBE_CYC - 1);

  sac_host_state_t s;
  sac_host_state_t next_s;
  logic aph;
  logic start;

  assign aph = HSEL && HTRANS[1] && HREADY;

  //--------------------------------------------------------------
  // next state
  //--------------------------------------------------------------
  always_comb begin
    next_s = s;
    start = 1'b0;
    // free-running conversion clock for external clock mode
    if (s.clk_run && s.div_cnt == HALF_LAST) begin
      next_s.div_cnt = 8'h00;
      next_s.conv_clk = ~s.conv_clk;
    end else if (s.clk_run) begin
      next_s.div_cnt = s.div_cnt + 8'h01;
    end else begin
      next_s.div_cnt = 8'h00;
    end
    // data phase of a write
    next_s.dph_wr = aph && HWRITE;
    next_s.dph_addr = HADDR[3:0];
    if (s.dph_wr) begin
      case (s.dph_addr)
        OFS_CTRL: begin
          start = 1'b1;
          if (s.phase == SAC_H_IDLE) begin
            next_s.ctrl = HWDATA[7:0];
            next_s.is_read = 1'b0;
          end
        end
        OFS_READ: begin
          start = 1'b1;
          if (s.phase == SAC_H_IDLE) begin
            next_s.is_read = 1'b1;
          end
        end
        OFS_STATUS: begin
          if (HWDATA[ST_DROP_BIT]) begin
            next_s.dropped = 1'b0;
          end
        end
        OFS_CLKCFG: begin
          next_s.clk_run = HWDATA[0];
        end
        default: begin
          next_s.dropped = s.dropped;
        end
      endcase
    end
    // strobe sequence: select, strobe low, strobe high with select held
    case (s.phase)
      SAC_H_IDLE: begin
        if (start) begin
          next_s.cs_b = 1'b0;
          next_s.phase = SAC_H_SETUP;
        end
      end
      SAC_H_SETUP: begin
        next_s.wr_b = s.is_read;
        next_s.rd_b = ~s.is_read;
        next_s.cnt = 2'h0;
        next_s.phase = SAC_H_STROBE;
      end
      SAC_H_STROBE: begin
        next_s.cnt = s.cnt + 2'h1;
        if (s.cnt == STROBE_LAST) begin
          next_s.wr_b = 1'b1;
          next_s.rd_b = 1'b1;
          next_s.phase = SAC_H_RELEASE;
        end
      end
      SAC_H_RELEASE: begin
        next_s.cs_b = 1'b1;
        next_s.phase = SAC_H_IDLE;
      end
      default: begin
        next_s.phase = SAC_H_IDLE;
      end
    endcase
    // set wins over the clear above
    if (start && s.phase != SAC_H_IDLE) begin
      next_s.dropped = 1'b1;
    end
    // read data registered during the address phase
    next_s.rdata = 32'h00000000;
    if (aph && !HWRITE) begin
      case (HADDR[3:0])
        OFS_CTRL: next_s.rdata = {24'h000000, s.ctrl};
        OFS_STATUS: begin
          next_s.rdata[ST_BUSY_BIT] = (s.phase != SAC_H_IDLE) || start;
          next_s.rdata[ST_DONE_BIT] = ~LINK.done_b;
          next_s.rdata[ST_DROP_BIT] = s.dropped;
        end
        OFS_CLKCFG: next_s.rdata = {31'h00000000, s.clk_run};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
  end

  //--------------------------------------------------------------
  // state register
  //--------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '{phase: SAC_H_IDLE, is_read: 1'b0, cnt: 2'h0, ctrl: CTRL_RESET, dropped: 1'b0,
        clk_run: CLKRUN_RESET, div_cnt: 8'h00, cs_b: 1'b1, wr_b: 1'b1, rd_b: 1'b1,
        conv_clk: 1'b0, dph_wr: 1'b0, dph_addr: 4'h0, rdata: 32'h00000000};
    end else if (CE) begin
      s <= next_s;
    end
  end

  assign HRDATA = s.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign LINK.cs_b = s.cs_b;
  assign LINK.wr_b = s.wr_b;
  assign LINK.rd_b = s.rd_b;
  assign LINK.data = s.ctrl;
  assign LINK.conv_clk = s.conv_clk;
endmodule : sac_host

// [design/sac_link_if.sv]
// Purpose: parallel control link between host and converter sequencer
// Assumes: all pins change on the common clock
// Notes: result data pins are outside this block
`timescale 1ns/1ns
interface sac_link_if;
  logic cs_b;
  logic wr_b;
  logic rd_b;
  logic [7:0] data;
  logic conv_clk;
  logic done_b;
  modport dev (input cs_b, input wr_b, input rd_b, input data, input conv_clk, output done_b);
  modport host (output cs_b, output wr_b, output rd_b, output data, output conv_clk,
    input done_b);
endinterface : sac_link_if

// [design/sac_pkg.sv]
// Purpose: shared constants and types for the converter sequencer and its host
// Assumes: one 20 MHz clock on both ends; link pins synchronous to it
// Notes:
package sac_pkg;
  // control byte layout
  localparam int PWR_HI_BIT = 7;
  localparam int PWR_LO_BIT = 6;
  localparam int ACQ_MODE_BIT = 5;
  localparam int CFG_SEL_BIT = 4;
  localparam int POL_SEL_BIT = 3;
  localparam int ADDR_MSB = 2;
  localparam logic [1:0] PWR_INT_CLK = 2'h2;
  localparam logic [1:0] PWR_EXT_CLK = 2'h3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // multiplexer select code of the common return input
  localparam logic [3:0] SEL_COMMON = 4'h8;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int ACQ_EDGES = 4;
  localparam int CONV_CYCLES = 13;
  localparam int INT_ACQ_TIME_NS = 1000;
  localparam int INT_TICK_CYC = INT_ACQ_TIME_NS / (ACQ_EDGES * CLK_PERIOD_NS);
  localparam int EXT_HALF_CYC = 4;
  localparam int STROBE_CYC = 2;
  // host register offsets and fields
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_READ = 4'h8;
  localparam logic [3:0] OFS_CLKCFG = 4'hC;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_DROP_BIT = 2;
  localparam logic CLKRUN_RESET = 1'b1;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_ACQ_INT = 2'b01,
    SAC_ACQ_EXT = 2'b10,
    SAC_CONV = 2'b11
  } sac_phase_t;

  typedef enum logic [1:0] {
    SAC_H_IDLE = 2'b00,
    SAC_H_SETUP = 2'b01,
    SAC_H_STROBE = 2'b10,
    SAC_H_RELEASE = 2'b11
  } sac_hphase_t;
endpackage : sac_pkg

// [verification/sac_link_assertions.sv]
// Purpose: timing checks on the host-to-sequencer link
// Assumes: one clock; conversion ticks are sampled conv_clk falls
// Notes: tick counts only checked with the external conversion clock
`timescale 1ns/1ns
module sac_link_assertions
  import sac_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic cs_b,
  input wire logic wr_b,
  input wire logic rd_b,
  input wire logic [7:0] data,
  input wire logic conv_clk,
  input wire logic done_b,
  input wire logic TRACK,
  input wire logic HOLD_CAP_NEG,
  input wire logic [3:0] MUX_POS_SEL,
  input wire logic [3:0] MUX_NEG_SEL,
  input wire logic CLK_MODE_INT,
  input wire logic BUSY
);
  logic wr_q;
  logic rd_q;
  logic ck_q;
  logic ext_acq;
  logic [3:0] acq_cnt;
  logic [3:0] conv_cnt;
  logic wr_rise;
  logic rd_fall;
  logic tick;
  assign wr_rise = !wr_q && wr_b && !cs_b;
  assign rd_fall = rd_q && !rd_b && !cs_b;
  assign tick = ck_q && !conv_clk && !CLK_MODE_INT;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_q <= 1'b1;
      rd_q <= 1'b1;
      ck_q <= 1'b0;
      ext_acq <= 1'b0;
      acq_cnt <= 4'h0;
      conv_cnt <= 4'h0;
    end else begin
      wr_q <= wr_b;
      rd_q <= rd_b;
      ck_q <= conv_clk;
      if (wr_rise) begin
        ext_acq <= !ext_acq && data[ACQ_MODE_BIT];
      end
      // saturate so idle ticks never wrap back into range
      if (wr_rise) begin
        acq_cnt <= 4'h0;
      end else if (tick && acq_cnt != 4'hF) begin
        acq_cnt <= acq_cnt + 4'h1;
      end
      if (wr_rise || !HOLD_CAP_NEG) begin
        conv_cnt <= 4'h0;
      end else if (tick) begin
        conv_cnt <= conv_cnt + 4'h1;
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_write_tracks: assert property (wr_rise && !ext_acq |=> TRACK && BUSY && !HOLD_CAP_NEG)
    else $error("write did not start tracking");
  a_ext_hold: assert property (wr_rise && ext_acq |=> !TRACK && HOLD_CAP_NEG)
    else $error("second write did not hold");
  a_ext_open: assert property (ext_acq |-> TRACK && BUSY)
    else $error("open acquisition ended early");
  a_single_mux: assert property (wr_rise && !ext_acq && data[CFG_SEL_BIT] |=>
    MUX_POS_SEL == {1'b0, $past(data[2:0])} && MUX_NEG_SEL == SEL_COMMON)
    else $error("single-ended routing wrong");
  a_pair_mux: assert property (wr_rise && !ext_acq && !data[CFG_SEL_BIT] |=>
    MUX_NEG_SEL == {1'b0, $past(data[2:0]) ^ 3'h1})
    else $error("pair routing wrong");
  a_acq_fourth: assert property (tick && acq_cnt == 4'h3 && TRACK && BUSY && !ext_acq
    && !wr_rise |=> !TRACK && HOLD_CAP_NEG)
    else $error("no hold on fourth tick");
  a_acq_early: assert property (tick && acq_cnt < 4'h3 && TRACK && BUSY && !ext_acq
    && !wr_rise |=> TRACK)
    else $error("hold came early");
  a_conv_len: assert property (tick && HOLD_CAP_NEG && conv_cnt == 4'hC && !wr_rise |=>
    !HOLD_CAP_NEG && !BUSY && !done_b)
    else $error("conversion not thirteen ticks");
  a_conv_keep: assert property (tick && HOLD_CAP_NEG && conv_cnt < 4'hC && !wr_rise |=>
    HOLD_CAP_NEG)
    else $error("conversion cut short");
  a_done_read: assert property (rd_fall && !done_b |=> done_b)
    else $error("done not cleared by read");
  a_done_stays: assert property (!done_b && !rd_fall && !wr_rise |=> !done_b)
    else $error("done dropped by itself");
endmodule : sac_link_assertions

// [verification/tb_sar_adc_acquisition_control.sv]
// Purpose: end-to-end bench, host controller driving the sequencer
// Assumes: external conversion clock unless a scenario picks internal
// Notes: a note is queued per conversion and checked when done falls
`timescale 1ns/1ns
module tb_sar_adc_acquisition_control;
  import sac_pkg::*;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic TRACK, HOLD_CAP_NEG, POLARITY_SELECT, CLK_MODE_INT, BUSY;
  logic [3:0] MUX_POS_SEL, MUX_NEG_SEL;
  logic [1:0] POWER_SELECT;
  int fails = 0;
  int checked = 0;
  integer seed = 32'h52d1;
  logic [10:0] notes[$];
  logic done_q = 1'b1;
  logic [31:0] rd;
  logic [7:0] b;
  always #25 CLK = ~CLK;
  sac_link_if u_sac_link_if ();
  sac_dev u_sac_dev (.CLK(CLK), .RST_B(RST_B), .CE(1'b1), .LINK(u_sac_link_if),
    .TRACK(TRACK), .HOLD_CAP_NEG(HOLD_CAP_NEG), .MUX_POS_SEL(MUX_POS_SEL),
    .MUX_NEG_SEL(MUX_NEG_SEL), .POLARITY_SELECT(POLARITY_SELECT),
    .POWER_SELECT(POWER_SELECT), .CLK_MODE_INT(CLK_MODE_INT), .BUSY(BUSY));
  sac_host u_sac_host (.CLK(CLK), .RST_B(RST_B), .CE(1'b1), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(), .LINK(u_sac_link_if));
  sac_link_assertions u_sac_link_assertions (.CLK(CLK), .RST_B(RST_B),
    .cs_b(u_sac_link_if.cs_b), .wr_b(u_sac_link_if.wr_b), .rd_b(u_sac_link_if.rd_b),
    .data(u_sac_link_if.data), .conv_clk(u_sac_link_if.conv_clk),
    .done_b(u_sac_link_if.done_b), .TRACK(TRACK), .HOLD_CAP_NEG(HOLD_CAP_NEG),
    .MUX_POS_SEL(MUX_POS_SEL), .MUX_NEG_SEL(MUX_NEG_SEL), .CLK_MODE_INT(CLK_MODE_INT),
    .BUSY(BUSY));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wait_for(input logic lvl, input bit on_done);
    int n;
    n = 0;
    @(posedge CLK);
    while ((on_done ? u_sac_link_if.done_b : HREADYOUT) !== lvl) begin
      n++;
      if (n > 3000) begin
        fails++;
        wrap_up();
      end
      @(posedge CLK);
    end
  endtask : wait_for
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {28'h0, a};
    HWRITE <= wr;
    wait_for(1'b1, 1'b0);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= d;
    wait_for(1'b1, 1'b0);
    rd = HRDATA;
  endtask : bus
  function automatic logic [10:0] expect_of(input logic [7:0] cb);
    logic [3:0] neg;
    neg = cb[CFG_SEL_BIT] ? SEL_COMMON : {1'b0, cb[2:0] ^ 3'h1};
    return {{1'b0, cb[2:0]}, neg, cb[POL_SEL_BIT], cb[7:6]};
  endfunction : expect_of
  // waits out the result, reads it back and lets the read strobe end
  task automatic finish_conv();
    wait_for(1'b0, 1'b1);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("status done", rd[ST_DONE_BIT], 1'b1);
    bus(1'b1, OFS_READ, 32'h0);
    wait_for(1'b1, 1'b1);
    repeat (6) @(posedge CLK);
  endtask : finish_conv
  task automatic convert(input logic [7:0] cb);
    notes.push_back(expect_of(cb));
    bus(1'b1, OFS_CTRL, {24'h0, cb});
    finish_conv();
  endtask : convert
  // ----------------------------------------
  // result monitor
  // ----------------------------------------
  always @(posedge CLK) begin
    done_q <= u_sac_link_if.done_b;
    if (RST_B && done_q && u_sac_link_if.done_b === 1'b0) begin
      if (notes.size() == 0)
        check("unexpected done", 1'b1, 1'b0);
      else
        check("setup", {MUX_POS_SEL, MUX_NEG_SEL, POLARITY_SELECT, POWER_SELECT},
          notes.pop_front());
    end
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    check("reset track", TRACK, 1'b1);
    check("reset neg", MUX_NEG_SEL, SEL_COMMON);
    @(posedge CLK);
    bus(1'b0, OFS_CLKCFG, 32'h0);
    check("clkcfg", rd, 32'h1);
    bus(1'b1, 4'h2, 32'hFF);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      b = 8'($random(seed));
      b[7:5] = 3'b110;
      b[CFG_SEL_BIT] = i[0];
      b[2:0] = i[3:1];
      convert(b);
    end
    // internal clock: conversion clock pin stopped
    bus(1'b1, OFS_CLKCFG, 32'h0);
    convert(8'h9D);
    check("int clock", CLK_MODE_INT, 1'b1);
    bus(1'b1, OFS_CLKCFG, 32'h1);
    bus(1'b1, OFS_CTRL, 32'hFB);
    repeat (40) @(posedge CLK);
    check("open acq", TRACK, 1'b1);
    convert(8'h5B);
    check("mode kept", CLK_MODE_INT, 1'b0);
    bus(1'b1, OFS_CTRL, 32'hCD);
    repeat (60) @(posedge CLK);
    check("mid conv", HOLD_CAP_NEG, 1'b1);
    convert(8'hC2);
    notes.push_back(expect_of(8'hD6));
    bus(1'b1, OFS_CTRL, 32'hD6);
    bus(1'b1, OFS_CTRL, 32'hD1);
    repeat (2) @(posedge CLK);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("dropped", rd[ST_DROP_BIT], 1'b1);
    bus(1'b1, OFS_STATUS, 32'h4);
    repeat (2) @(posedge CLK);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("drop clear", rd[ST_DROP_BIT], 1'b0);
    finish_conv();
    check("notes left", notes.size(), 32'h0);
    wrap_up();
  end
endmodule : tb_sar_adc_acquisition_control
